//--- port_status_pkg.sv
package port_status_pkg;

  localparam int          NUM_PORTS          = 16;
  localparam int          ADDR_W             = 12;

  // Per-port status words: one aligned word per port
  localparam logic [11:0] STATUS_BASE_OFS    = 12'h158;
  localparam logic [11:0] STATUS_LAST_OFS    = 12'h338;
  localparam int          STATUS_STRIDE_LSB  = 5;

  // Interrupt block
  localparam logic [11:0] IRQ_STATUS_OFS     = 12'h400;
  localparam logic [11:0] IRQ_ENABLE_OFS     = 12'h404;
  localparam logic [11:0] IRQ_CLEAR_OFS      = 12'h408;

  localparam logic [31:0] POWERED_DOWN_VALUE = 32'h0000_0001;
  localparam logic [31:0] STATUS_RESET_VALUE = 32'h0000_0001;
  localparam logic [15:0] IRQ_ENABLE_RESET   = 16'h0000;

  // Bit 0 is the most significant bit of the word
  localparam int          MSB_FIRST          = 31;
  localparam int          POS_DISCARD        = MSB_FIRST - 5;
  localparam int          POS_FAILED         = MSB_FIRST - 6;
  localparam int          POS_DEGRADED       = MSB_FIRST - 7;
  localparam int          POS_RETRY_SEEN     = MSB_FIRST - 11;
  localparam int          POS_RETRIED        = MSB_FIRST - 12;
  localparam int          POS_RETRY_HALTED   = MSB_FIRST - 13;
  localparam int          POS_EG_ERR_SEEN    = MSB_FIRST - 14;
  localparam int          POS_EG_ERR_HALTED  = MSB_FIRST - 15;
  localparam int          POS_IN_RETRY_HALT  = MSB_FIRST - 21;
  localparam int          POS_IN_ERR_SEEN    = MSB_FIRST - 22;
  localparam int          POS_IN_ERR_HALTED  = MSB_FIRST - 23;
  localparam int          POS_NOTIFY_PEND    = MSB_FIRST - 27;
  localparam int          POS_FATAL          = MSB_FIRST - 29;
  localparam int          POS_INITIALIZED    = MSB_FIRST - 30;
  localparam int          POS_NOT_INIT       = MSB_FIRST - 31;

  typedef struct packed {
    logic discard_evt;
    logic fail_thresh_evt;
    logic degrade_thresh_evt;
    logic ack_symbol_rx;
    logic egress_retry_halted;
    logic egress_err_halted;
    logic ingress_retry_halted;
    logic ingress_err_halted;
    logic notify_evt;
    logic lreq_noack_evt;
    logic lreq_timeout_evt;
    logic dead_link_evt;
    logic lane_sync_evt;
    logic link_ready;
    logic powered_down;
  } port_events_t;

  typedef struct packed {
    logic egress_discard_flag;
    logic egress_failed_flag;
    logic egress_degraded_flag;
    logic egress_retry_seen_flag;
    logic egress_retried_flag;
    logic egress_retry_halted_state;
    logic egress_err_seen_flag;
    logic egress_err_halted_state;
    logic ingress_retry_halted_state;
    logic ingress_err_seen_flag;
    logic ingress_err_halted_state;
    logic notify_write_pending_flag;
    logic fatal_fault_flag;
    logic link_initialized_flag;
  } port_state_t;

  typedef struct packed {
    logic [31:0]                  rdata;
    logic                         wr_pend;
    logic                         wr_addr_ok;
    logic [ADDR_W-1:0]            wr_addr;
    logic [NUM_PORTS-1:0]         irq_status;
    logic [NUM_PORTS-1:0]         irq_enable;
    port_state_t [NUM_PORTS-1:0]  ports;
  } state_t;

endpackage

//--- port_status_regs.sv
`timescale 1ns/1ps
module port_status_regs (
  input  wire logic                                       sys_clk,
  input  wire logic                                       rst_n,
  input  wire logic                                       hsel,
  input  wire logic [31:0]                                haddr,
  input  wire logic [1:0]                                 htrans,
  input  wire logic                                       hwrite,
  input  wire logic [2:0]                                 hsize,
  input  wire logic [31:0]                                hwdata,
  input  wire logic                                       hready,
  output logic                                            hreadyout,
  output logic                                            hresp,
  output logic [31:0]                                     hrdata,
  input  port_status_pkg::port_events_t [port_status_pkg::NUM_PORTS-1:0] port_evt,
  output logic                                            irq
);
  import port_status_pkg::*;

  state_t state_ff;
  state_t nxt_state;

  // Returns {hit, index} for a per-port status word offset
  function automatic logic [4:0] port_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    logic              hit;
    d   = a - STATUS_BASE_OFS;
    hit = (a >= STATUS_BASE_OFS) && (a <= STATUS_LAST_OFS)
          && (d[STATUS_STRIDE_LSB-1:0] == '0);
    return {hit, d[STATUS_STRIDE_LSB+3:STATUS_STRIDE_LSB]};
  endfunction

  // Set wins over a same-cycle clear
  function automatic logic sticky(input logic old, input logic set, input logic clr);
    return set | (old & ~clr);
  endfunction

  function automatic logic [31:0] port_word(input port_state_t s, input logic pd);
    logic [31:0] w;
    w = '0;
    w[POS_DISCARD]       = s.egress_discard_flag;
    w[POS_FAILED]        = s.egress_failed_flag;
    w[POS_DEGRADED]      = s.egress_degraded_flag;
    w[POS_RETRY_SEEN]    = s.egress_retry_seen_flag;
    w[POS_RETRIED]       = s.egress_retried_flag;
    w[POS_RETRY_HALTED]  = s.egress_retry_halted_state;
    w[POS_EG_ERR_SEEN]   = s.egress_err_seen_flag;
    w[POS_EG_ERR_HALTED] = s.egress_err_halted_state;
    w[POS_IN_RETRY_HALT] = s.ingress_retry_halted_state;
    w[POS_IN_ERR_SEEN]   = s.ingress_err_seen_flag;
    w[POS_IN_ERR_HALTED] = s.ingress_err_halted_state;
    w[POS_NOTIFY_PEND]   = s.notify_write_pending_flag;
    w[POS_FATAL]         = s.fatal_fault_flag;
    w[POS_INITIALIZED]   = s.link_initialized_flag;
    w[POS_NOT_INIT]      = ~s.link_initialized_flag;
    if (pd)
    begin
      w = POWERED_DOWN_VALUE;
    end
    return w;
  endfunction

  logic [4:0]  wr_dec;
  logic [4:0]  rd_dec;
  logic        addr_phase;
  logic        haddr_ok;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state_ff.rdata;
  assign irq       = |(state_ff.irq_status & state_ff.irq_enable);

  assign wr_dec     = port_decode(state_ff.wr_addr);
  assign rd_dec     = port_decode(haddr[ADDR_W-1:0]);
  assign addr_phase = hsel & htrans[1] & hready;
  assign haddr_ok   = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'b00);

  always_comb
  begin
    port_state_t          s;
    port_state_t          n;
    port_events_t         e;
    logic [31:0]          clr;
    logic                 eg_retry_rise;
    logic                 eg_err_rise;
    logic                 in_err_rise;
    logic                 any_set;
    logic [NUM_PORTS-1:0] irq_set;
    logic [NUM_PORTS-1:0] irq_clr;
    logic                 wr_live;
    s             = '0;
    n             = '0;
    e             = '0;
    clr           = '0;
    eg_retry_rise = 1'b0;
    eg_err_rise   = 1'b0;
    in_err_rise   = 1'b0;
    any_set       = 1'b0;
    irq_set       = '0;
    irq_clr       = '0;
    wr_live       = state_ff.wr_pend & state_ff.wr_addr_ok;
    nxt_state     = state_ff;

    for (int p = 0; p < NUM_PORTS; p++)
    begin
      e   = port_evt[p];
      s   = state_ff.ports[p];
      n   = s;
      clr = (wr_live && wr_dec[4] && (wr_dec[3:0] == 4'(p))) ? hwdata : '0;

      // Live copies double as the previous value for edge detection
      eg_retry_rise = e.egress_retry_halted & ~s.egress_retry_halted_state;
      eg_err_rise   = e.egress_err_halted & ~s.egress_err_halted_state;
      in_err_rise   = e.ingress_err_halted & ~s.ingress_err_halted_state;

      n.egress_discard_flag  = sticky(s.egress_discard_flag, e.discard_evt,
                                      clr[POS_DISCARD]);
      n.egress_failed_flag   = sticky(s.egress_failed_flag, e.fail_thresh_evt,
                                      clr[POS_FAILED]);
      n.egress_degraded_flag = sticky(s.egress_degraded_flag, e.degrade_thresh_evt,
                                      clr[POS_DEGRADED]);
      n.egress_retry_seen_flag = sticky(s.egress_retry_seen_flag, eg_retry_rise,
                                        clr[POS_RETRY_SEEN]);
      if (eg_retry_rise)
      begin
        n.egress_retried_flag = 1'b1;
      end
      else if (e.ack_symbol_rx)
      begin
        n.egress_retried_flag = 1'b0;
      end
      n.egress_retry_halted_state  = e.egress_retry_halted;
      n.egress_err_seen_flag       = sticky(s.egress_err_seen_flag, eg_err_rise,
                                            clr[POS_EG_ERR_SEEN]);
      n.egress_err_halted_state    = e.egress_err_halted;
      n.ingress_retry_halted_state = e.ingress_retry_halted;
      n.ingress_err_seen_flag      = sticky(s.ingress_err_seen_flag, in_err_rise,
                                            clr[POS_IN_ERR_SEEN]);
      n.ingress_err_halted_state   = e.ingress_err_halted;
      n.notify_write_pending_flag  = sticky(s.notify_write_pending_flag, e.notify_evt,
                                            clr[POS_NOTIFY_PEND]);
      n.fatal_fault_flag = sticky(s.fatal_fault_flag,
                                  e.lreq_noack_evt | e.lreq_timeout_evt
                                  | e.dead_link_evt | e.lane_sync_evt,
                                  clr[POS_FATAL]);
      n.link_initialized_flag = e.link_ready;

      // A port raises its interrupt bit when any sticky flag newly sets
      any_set = (n.egress_discard_flag & ~s.egress_discard_flag)
              | (n.egress_failed_flag & ~s.egress_failed_flag)
              | (n.egress_degraded_flag & ~s.egress_degraded_flag)
              | (n.egress_retry_seen_flag & ~s.egress_retry_seen_flag)
              | (n.egress_err_seen_flag & ~s.egress_err_seen_flag)
              | (n.ingress_err_seen_flag & ~s.ingress_err_seen_flag)
              | (n.notify_write_pending_flag & ~s.notify_write_pending_flag)
              | (n.fatal_fault_flag & ~s.fatal_fault_flag);
      irq_set[p] = any_set;
      nxt_state.ports[p] = n;
    end

    if (wr_live && (state_ff.wr_addr == IRQ_CLEAR_OFS))
    begin
      irq_clr = hwdata[NUM_PORTS-1:0];
    end
    if (wr_live && (state_ff.wr_addr == IRQ_ENABLE_OFS))
    begin
      nxt_state.irq_enable = hwdata[NUM_PORTS-1:0];
    end
    nxt_state.irq_status = irq_set | (state_ff.irq_status & ~irq_clr);

    // Data phase closes every cycle; zero wait states
    nxt_state.wr_pend = 1'b0;
    if (addr_phase)
    begin
      nxt_state.wr_pend    = hwrite;
      nxt_state.wr_addr_ok = haddr_ok;
      nxt_state.wr_addr    = haddr[ADDR_W-1:0];
      if (!hwrite)
      begin
        // Read sampled at the address phase; a write in the same edge is not yet seen
        nxt_state.rdata = '0;
        if (haddr_ok && rd_dec[4])
        begin
          nxt_state.rdata = port_word(state_ff.ports[rd_dec[3:0]],
                                      port_evt[rd_dec[3:0]].powered_down);
        end
        else if (haddr_ok && (haddr[ADDR_W-1:0] == IRQ_STATUS_OFS))
        begin
          nxt_state.rdata = {{(32-NUM_PORTS){1'b0}}, state_ff.irq_status};
        end
        else if (haddr_ok && (haddr[ADDR_W-1:0] == IRQ_ENABLE_OFS))
        begin
          nxt_state.rdata = {{(32-NUM_PORTS){1'b0}}, state_ff.irq_enable};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff            <= '0;
      state_ff.irq_enable <= IRQ_ENABLE_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

endmodule

//--- HANDOVER_unused_marker_none.sv
`timescale 1ns/1ps

//--- port_status_regs_sva.sv
`timescale 1ns/1ps
module port_status_regs_sva (
  input wire logic                                  sys_clk,
  input wire logic                                  rst_n,
  input wire logic                                  hsel,
  input wire logic [31:0]                           haddr,
  input wire logic [1:0]                            htrans,
  input wire logic                                  hwrite,
  input wire logic                                  hready,
  input wire logic                                  hreadyout,
  input wire logic                                  hresp,
  input wire logic [31:0]                           hrdata,
  input wire port_status_pkg::port_events_t [port_status_pkg::NUM_PORTS-1:0] port_evt
);
  import port_status_pkg::*;
  logic rd0;
  logic up0;
  // Port 0 only: enough to tie each read to its cause
  assign rd0 = hsel && htrans[1] && hready && !hwrite && haddr == 32'h0000_0158;
  assign up0 = rd0 && !port_evt[0].powered_down;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_pd_fixed: assert property (rd0 && port_evt[0].powered_down |=>
    hrdata == POWERED_DOWN_VALUE) else $error("powered-down read wrong");
  a_rsvd_zero: assert property (rd0 |=> (hrdata & 32'hF8E0_F8E8) == 32'h0)
    else $error("reserved bit set");
  a_init_excl: assert property (rd0 |=> hrdata[1] != hrdata[0])
    else $error("init flags not exclusive");
  a_link_ok: assert property (up0 && $past(port_evt[0].link_ready)
    && port_evt[0].link_ready |=> hrdata[1:0] == 2'b10) else $error("initialized flag wrong");
  a_eg_err_live: assert property (up0 && $past(port_evt[0].egress_err_halted)
    && port_evt[0].egress_err_halted |=> hrdata[16]) else $error("egress err halted");
  // Sticky copies are checked only just after the rise: software may clear them later
  a_eg_err_seen: assert property (up0 && $past(port_evt[0].egress_err_halted)
    && !$past(port_evt[0].egress_err_halted, 2) |=> hrdata[17]) else $error("egress err seen");
  a_in_err_seen: assert property (up0 && $past(port_evt[0].ingress_err_halted)
    && !$past(port_evt[0].ingress_err_halted, 2) |=> hrdata[9:8] == 2'b11)
    else $error("ingress err seen");
  a_in_retry_live: assert property (up0 && $past(port_evt[0].ingress_retry_halted)
    && port_evt[0].ingress_retry_halted |=> hrdata[10]) else $error("ingress retry");
  a_retry_live: assert property (up0 && $past(port_evt[0].egress_retry_halted)
    && port_evt[0].egress_retry_halted |=> hrdata[18]) else $error("retry halted");
  a_retry_pair: assert property (up0 && $past(port_evt[0].egress_retry_halted)
    && !$past(port_evt[0].egress_retry_halted, 2) |=> hrdata[20] && hrdata[19])
    else $error("retry seen");
endmodule
bind port_status_regs port_status_regs_sva u_sva (.sys_clk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .port_evt);

//--- link_events_model.sv
`timescale 1ns/1ps
module link_events_model (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          fire,
  input  wire logic [3:0]                    sel,
  input  wire port_status_pkg::port_events_t req,
  output port_status_pkg::port_events_t [port_status_pkg::NUM_PORTS-1:0] port_evt
);
  import port_status_pkg::*;
  // State levels persist; events are one-cycle pulses, as the link logic gives them
  localparam logic [14:0] LEVEL_MASK = 15'h0783;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      port_evt <= '0;
    else
      for (int p = 0; p < NUM_PORTS; p++)
        port_evt[p] <= (fire && sel == 4'(p)) ? req : port_events_t'(port_evt[p] & LEVEL_MASK);
  end
endmodule

//--- serial_port_error_status_reg_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module serial_port_error_status_reg_test;
  import port_status_pkg::*;
  logic                           sys_clk = 1'b0;
  logic                           rst_n = 1'b0;
  logic                           hsel = 1'b0;
  logic [31:0]                    haddr = '0;
  logic [1:0]                     htrans = '0;
  logic                           hwrite = 1'b0;
  logic [31:0]                    hwdata = '0;
  logic                           hready;
  logic                           hreadyout;
  logic                           hresp;
  logic [31:0]                    hrdata;
  logic                           irq;
  logic                           fire = 1'b0;
  logic [3:0]                     sel = '0;
  port_events_t                   req = '0;
  port_events_t [NUM_PORTS-1:0]   port_evt;
  int                             n_errors = 0;
  int                             n_tests = 0;
  int                             cycles = 0;
  int                             evb[8] = '{14, 13, 12, 6, 5, 4, 3, 2};
  int                             hwb[8] = '{26, 25, 24, 4, 2, 2, 2, 2};
  logic [14:0]                    lvb[3] = '{15'h0200, 15'h0100, 15'h0080};
  logic [31:0]                    lvon[3] = '{32'h0003_0001, 32'h0000_0401, 32'h0000_0301};
  logic [31:0]                    lvoff[3] = '{32'h0002_0001, 32'h0000_0001, 32'h0000_0201};
  assign hready = hreadyout;
  port_status_regs dut (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .port_evt, .irq);
  link_events_model partner (.sys_clk, .rst_n, .fire, .sel, .req, .port_evt);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    `CHK(nm, ex, d)
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic ev(input int p, input logic [14:0] b);
    @(posedge sys_clk);
    sel  <= 4'(p);
    req  <= port_events_t'(b);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask
  function automatic logic [31:0] st(input int p);
    return 32'(STATUS_BASE_OFS) + 32'(p) * 32'h20;
  endfunction
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int p = 0; p < NUM_PORTS; p++)
      rchk("reset word", st(p), 32'h1);
    rchk("gap", 32'h15C, 32'h0);
    rchk("past last", 32'h358, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      ev(3, 15'h1 << evb[i]);
      rchk("sticky", st(3), 32'h1 | (32'h1 << hwb[i]));
      wr(st(3), 32'h0);
      rchk("zero write", st(3), 32'h1 | (32'h1 << hwb[i]));
      wr(st(3), 32'h1 << hwb[i]);
      rchk("cleared", st(3), 32'h1);
    end
    $display("test sticky done");
    ev(0, 15'h0400);
    rchk("retry halt", st(0), 32'h001C_0001);
    ev(0, 15'h0C00);
    rchk("retry ack", st(0), 32'h0014_0001);
    ev(0, 15'h0);
    rchk("retry gone", st(0), 32'h0010_0001);
    wr(st(0), 32'h0010_0000);
    rchk("retry clear", st(0), 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      ev(0, lvb[i]);
      rchk("level on", st(0), lvon[i]);
      ev(0, 15'h0);
      rchk("level off", st(0), lvoff[i]);
      wr(st(0), 32'hFFFF_FFFF);
      rchk("all ones", st(0), 32'h1);
    end
    $display("test levels done");
    ev(0, 15'h0002);
    rchk("link up", st(0), 32'h2);
    ev(0, 15'h4001);
    rchk("powered down", st(0), POWERED_DOWN_VALUE);
    ev(0, 15'h0002);
    rchk("after power", st(0), 32'h0400_0002);
    ev(0, 15'h0);
    wr(st(0), 32'hFFFF_FFFF);
    $display("test link done");
    wr(32'(IRQ_CLEAR_OFS), 32'hFFFF);
    rchk("irq idle", 32'(IRQ_STATUS_OFS), 32'h0);
    ev(3, 15'h4000);
    rchk("irq pend", 32'(IRQ_STATUS_OFS), 32'h8);
    `CHK("irq masked", 1'b0, irq)
    wr(32'(IRQ_STATUS_OFS), 32'h0);
    wr(32'(IRQ_ENABLE_OFS), 32'h8);
    rchk("irq enable", 32'(IRQ_ENABLE_OFS), 32'h8);
    `CHK("irq on", 1'b1, irq)
    wr(32'(IRQ_CLEAR_OFS), 32'h8);
    rchk("irq clear", 32'(IRQ_CLEAR_OFS), 32'h0);
    rchk("irq status", 32'(IRQ_STATUS_OFS), 32'h0);
    `CHK("irq off", 1'b0, irq)
    $display("test irq done");
    stop_test();
  end
endmodule
